// ---- pmd_consts.svh ----
// Functional notes
// - Unified space holds 16M words, 24-bit addresses
// - Program and data buses each reach everything
// - 256 pages of 64K, page from top byte
// - Lower half of page 0 is two 16K on-chip RAM blocks
// - Boot ROM top 1K of page 255
// - Four external banks, own low-active selects
// - 1K I/O pages with own low select
// - I/O pages 0-31 stay on chip
// - Data address is page register plus index
// - Program counter counts linearly, relative base
// - Direct branch loads full 24-bit target
// - Indirect branch uses jump page register
// - Peripheral boot starts at boot ROM
// - 16K on-chip ROM in program space
// - Protection blocks emulator access to ROM
// - Core and DMA reach whole map
// - Bank picked by page against boundaries
// - Reset boundaries 1-63, 64-127, 128-191, 192-254
// - I/O address is page plus 10-bit offset
`ifndef PMD_CONSTS_SVH
`define PMD_CONSTS_SVH
`define PMD_ADDR_W 24
`define PMD_PAGE_W 8
`define PMD_INDEX_W 16
`define PMD_IO_OFS_W 10
`define PMD_IO_ADDR_W 18
`define PMD_RAM_BLK_BIT 14
`define PMD_RAM_TOP_BIT 15
`define PMD_LAST_PAGE 8'hff
`define PMD_BOOT_BASE 16'hfc00
`define PMD_ROM_PAGE 8'h01
`define PMD_ROM_BASE 16'h0000
`define PMD_ROM_LIMIT 16'h3fff
`define PMD_IO_ONCHIP_LAST 8'h1f
`define PMD_BANK0_FIRST 8'h01
`define PMD_BANK1_FIRST 8'h40
`define PMD_BANK2_FIRST 8'h80
`define PMD_BANK3_FIRST 8'hc0
`define PMD_BANK3_LAST 8'hfe
`define PMD_BOOT_VECTOR 24'hfffc00
`define PMD_RESET_VECTOR 24'h000000
`endif

// ---- pmd_pkg.sv ----
`default_nettype none
package pmd_pkg;
    // Which source drives the program address this cycle
    typedef enum logic [3:0] {
        PMD_SEQ_LINEAR = 4'h1,
        PMD_SEQ_RELATIVE = 4'h2,
        PMD_SEQ_DIRECT = 4'h4,
        PMD_SEQ_INDIRECT = 4'h8
    } pmd_seq_type;
    // Decoded target of one access
    typedef enum logic [7:0] {
        PMD_TGT_NONE = 8'h01,
        PMD_TGT_RAM0 = 8'h02,
        PMD_TGT_RAM1 = 8'h04,
        PMD_TGT_BOOT = 8'h08,
        PMD_TGT_ROM = 8'h10,
        PMD_TGT_EXT = 8'h20,
        PMD_TGT_IO_INT = 8'h40,
        PMD_TGT_IO_EXT = 8'h80
    } pmd_tgt_type;
endpackage
`default_nettype wire

// ---- pmd_decoder.sv ----
`include "pmd_consts.svh"
`default_nettype none
module pmd_decoder #(
    parameter int ADDR_W = `PMD_ADDR_W
) (
    input wire logic clk_sys, // Core clock
    input wire logic rst, // Async reset, high
    input wire logic peripheral_boot, // Boot strap: peripheral boot
    input wire logic rom_protect, // Factory ROM protection option
    input wire logic seq_step, // Program counter advances
    input wire pmd_pkg::pmd_seq_type seq_sel, // Program address source
    input wire logic [15:0] seq_rel_ofs, // Signed relative offset
    input wire logic [ADDR_W-1:0] seq_direct, // Direct branch target
    input wire logic [15:0] seq_ind_index, // Indirect branch low bits
    input wire logic jump_page_we, // Load jump page register
    input wire logic [7:0] jump_page_wdata, // Jump page value
    input wire logic [1:0] dag_page_we, // Load data page register
    input wire logic [7:0] dag_page_wdata, // Data page value
    input wire logic dag_req, // Data access request
    input wire logic dag_sel, // Which data address generator
    input wire logic [15:0] dag_index, // Data address generator index
    input wire logic dma_req, // DMA access request
    input wire logic [ADDR_W-1:0] dma_addr, // DMA full address
    input wire logic emu_req, // Emulator access request
    input wire logic [ADDR_W-1:0] emu_addr, // Emulator address
    input wire logic io_page_we, // Load I/O page register
    input wire logic [7:0] io_page_wdata, // I/O page value
    input wire logic io_req, // I/O space request
    input wire logic [9:0] io_ofs, // I/O immediate offset
    input wire logic bank_we, // Load one bank boundary
    input wire logic [1:0] bank_wsel, // Bank boundary index
    input wire logic [7:0] bank_wfirst, // First page of bank
    input wire logic [3:0] bank_wait_in, // Bank waitstate count
    input wire logic bank_wmode_in, // Bank waitstate mode
    output logic [ADDR_W-1:0] program_address_bus, // Fetch address
    output logic [ADDR_W-1:0] data_address_bus, // Data/DMA address
    output logic [`PMD_IO_ADDR_W-1:0] io_address_bus, // I/O address
    output logic [1:0] ram_select, // On-chip RAM block select
    output logic boot_rom_select, // Boot ROM select
    output logic rom_select, // Program ROM select
    output logic io_reg_select, // On-chip peripheral registers
    output logic [3:0] external_bank_selects_n, // Bank selects, low
    output logic io_space_select_n, // External I/O select, low
    output logic [3:0] ext_wait, // Waitstates of selected bank
    output logic ext_wait_mode, // Waitstate mode of selected bank
    output logic emu_refused // Emulator access refused
);
    import pmd_pkg::*;

    // ********************************************************
    // Page registers and boundaries
    // ********************************************************
    logic [ADDR_W-1:0] pc_q;
    logic [7:0] jump_page_register_q;
    logic [7:0] data_page_register_q [2];
    logic [7:0] io_page_register_q;
    logic [7:0] bank_first_q [4];
    logic [3:0] bank_wait_q [4];
    logic bank_mode_q [4];
    logic boot_pending_q;
    logic [ADDR_W-1:0] pc_d;
    logic [ADDR_W-1:0] daddr;
    logic [ADDR_W-1:0] aaddr;
    logic a_valid;
    logic a_emu;
    pmd_tgt_type tgt;
    logic [1:0] bank;

    // Bank whose range holds the page
    function automatic logic [1:0] bank_of(input logic [7:0] pg,
            input logic [7:0] f1, input logic [7:0] f2,
            input logic [7:0] f3);
        if (pg >= f3) begin
            bank_of = 2'd3;
        end else if (pg >= f2) begin
            bank_of = 2'd2;
        end else if (pg >= f1) begin
            bank_of = 2'd1;
        end else begin
            bank_of = 2'd0;
        end
    endfunction

    // Target of one unified-space address
    function automatic pmd_tgt_type map_of(input logic [23:0] a,
            input logic pgm);
        logic [7:0] pg;
        logic [15:0] ix;
        pg = a[23:16];
        ix = a[15:0];
        if (pg == 8'h00) begin
            map_of = ix[`PMD_RAM_TOP_BIT] ? PMD_TGT_NONE :
                (ix[`PMD_RAM_BLK_BIT] ? PMD_TGT_RAM1 : PMD_TGT_RAM0);
        end else if (pg == `PMD_LAST_PAGE) begin
            // Below the boot ROM the top page is not off-chip
            map_of = (ix >= `PMD_BOOT_BASE) ? PMD_TGT_BOOT :
                PMD_TGT_NONE;
        end else if (pgm && pg == `PMD_ROM_PAGE &&
                ix <= `PMD_ROM_LIMIT) begin
            map_of = PMD_TGT_ROM;
        end else begin
            map_of = PMD_TGT_EXT;
        end
    endfunction

    // Bank boundaries, waitstates and modes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bank_first_q[0] <= `PMD_BANK0_FIRST;
            bank_first_q[1] <= `PMD_BANK1_FIRST;
            bank_first_q[2] <= `PMD_BANK2_FIRST;
            bank_first_q[3] <= `PMD_BANK3_FIRST;
            for (int i = 0; i < 4; i++) begin
                bank_wait_q[i] <= 4'h0;
                bank_mode_q[i] <= 1'b0;
            end
        end else if (bank_we) begin
            bank_first_q[bank_wsel] <= bank_wfirst;
            bank_wait_q[bank_wsel] <= bank_wait_in;
            bank_mode_q[bank_wsel] <= bank_wmode_in;
        end
    end

    // Page registers loaded by software
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            jump_page_register_q <= 8'h00;
            data_page_register_q[0] <= 8'h00;
            data_page_register_q[1] <= 8'h00;
            io_page_register_q <= 8'h00;
        end else begin
            if (jump_page_we) begin
                jump_page_register_q <= jump_page_wdata;
            end
            for (int i = 0; i < 2; i++) begin
                if (dag_page_we[i]) begin
                    data_page_register_q[i] <= dag_page_wdata;
                end
            end
            if (io_page_we) begin
                io_page_register_q <= io_page_wdata;
            end
        end
    end

    // ********************************************************
    // Program sequencer address
    // ********************************************************
    always_comb begin
        case (seq_sel)
            PMD_SEQ_LINEAR: pc_d = pc_q + 24'h000001;
            PMD_SEQ_RELATIVE: pc_d = pc_q + {{8{seq_rel_ofs[15]}},
                seq_rel_ofs};
            PMD_SEQ_DIRECT: pc_d = seq_direct;
            PMD_SEQ_INDIRECT: pc_d = {jump_page_register_q,
                seq_ind_index};
            default: pc_d = pc_q;
        endcase
    end

    // Program counter, starting at boot ROM on peripheral boot
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pc_q <= `PMD_RESET_VECTOR;
            boot_pending_q <= 1'b1;
        end else if (boot_pending_q) begin
            boot_pending_q <= 1'b0;
            pc_q <= peripheral_boot ? `PMD_BOOT_VECTOR :
                `PMD_RESET_VECTOR;
        end else if (seq_step) begin
            pc_q <= pc_d;
        end
    end

    // ********************************************************
    // Data side address and decode
    // ********************************************************
    always_comb begin
        daddr = {data_page_register_q[dag_sel], dag_index};
        a_emu = 1'b0;
        a_valid = 1'b1;
        if (dma_req) begin
            aaddr = dma_addr;
        end else if (dag_req) begin
            aaddr = daddr;
        end else if (emu_req) begin
            aaddr = emu_addr;
            a_emu = 1'b1;
        end else begin
            aaddr = pc_q;
            a_valid = !boot_pending_q;
        end
        if (io_req) begin
            tgt = (io_page_register_q <= `PMD_IO_ONCHIP_LAST) ?
                PMD_TGT_IO_INT : PMD_TGT_IO_EXT;
        end else if (a_valid) begin
            tgt = map_of(aaddr, 1'b1);
        end else begin
            tgt = PMD_TGT_NONE;
        end
        bank = bank_of(aaddr[23:16], bank_first_q[1], bank_first_q[2],
            bank_first_q[3]);
    end

    // Registered selects, at most one target at a time
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            program_address_bus <= `PMD_RESET_VECTOR;
            data_address_bus <= '0;
            io_address_bus <= '0;
            ram_select <= 2'b00;
            boot_rom_select <= 1'b0;
            rom_select <= 1'b0;
            io_reg_select <= 1'b0;
            external_bank_selects_n <= 4'hf;
            io_space_select_n <= 1'b1;
            ext_wait <= 4'h0;
            ext_wait_mode <= 1'b0;
            emu_refused <= 1'b0;
        end else begin
            program_address_bus <= pc_q;
            data_address_bus <= aaddr;
            io_address_bus <= {io_page_register_q, io_ofs};
            ram_select <= {tgt == PMD_TGT_RAM1, tgt == PMD_TGT_RAM0};
            boot_rom_select <= (tgt == PMD_TGT_BOOT) &&
                !(a_emu && rom_protect);
            emu_refused <= a_emu && rom_protect &&
                (tgt == PMD_TGT_ROM || tgt == PMD_TGT_BOOT);
            rom_select <= (tgt == PMD_TGT_ROM) &&
                !(a_emu && rom_protect);
            io_reg_select <= tgt == PMD_TGT_IO_INT;
            io_space_select_n <= !(tgt == PMD_TGT_IO_EXT);
            external_bank_selects_n <= (tgt == PMD_TGT_EXT) ?
                ~(4'h1 << bank) : 4'hf;
            ext_wait <= bank_wait_q[bank];
            ext_wait_mode <= bank_mode_q[bank];
        end
    end

    // ********************************************************
    // Checks
    // ********************************************************
    // Steps of a program counter change
    sequence s_step_linear;
        !boot_pending_q && seq_step && seq_sel == PMD_SEQ_LINEAR;
    endsequence
    sequence s_step_direct;
        !boot_pending_q && seq_step && seq_sel == PMD_SEQ_DIRECT;
    endsequence
    sequence s_step_indirect;
        !boot_pending_q && seq_step && seq_sel == PMD_SEQ_INDIRECT;
    endsequence
    a_one_target: assert property (
        @(posedge clk_sys) disable iff (rst)
        $onehot0({ram_select, boot_rom_select, rom_select, io_reg_select,
        ~external_bank_selects_n, ~io_space_select_n}))
        else $error("more than one target selected");
    a_io_low_pages: assert property (
        @(posedge clk_sys) disable iff (rst)
        io_req && io_page_register_q <= `PMD_IO_ONCHIP_LAST |=>
        io_space_select_n && io_reg_select)
        else $error("low I/O page went off chip");
    a_io_high_pages: assert property (
        @(posedge clk_sys) disable iff (rst)
        io_req && io_page_register_q > `PMD_IO_ONCHIP_LAST |=>
        !io_space_select_n && !io_reg_select)
        else $error("external I/O select missing");
    a_data_form: assert property (
        @(posedge clk_sys) disable iff (rst)
        dag_req && !dma_req |=> data_address_bus ==
        {$past(data_page_register_q[dag_sel]), $past(dag_index)})
        else $error("data address wrong");
    a_pc_linear: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_step_linear |=> pc_q == $past(pc_q) + 24'h000001)
        else $error("pc not linear");
    a_direct_load: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_step_direct |=> ##1 program_address_bus == $past(seq_direct, 2))
        else $error("direct target lost");
    a_indirect_jump: assert property (
        @(posedge clk_sys) disable iff (rst)
        s_step_indirect |=>
        pc_q == {$past(jump_page_register_q), $past(seq_ind_index)})
        else $error("indirect target wrong");
    a_rom_guard: assert property (
        @(posedge clk_sys) disable iff (rst)
        emu_refused |-> !rom_select && !boot_rom_select ##0
        $past(rom_protect)) else $error("protected rom reached");
    a_boot_start: assert property (
        @(posedge clk_sys) disable iff (rst)
        boot_pending_q && peripheral_boot |=> pc_q == `PMD_BOOT_VECTOR)
        else $error("boot not from rom");
    a_ram_blocks: assert property (
        @(posedge clk_sys) disable iff (rst)
        dma_req && !io_req && dma_addr[23:15] == 9'h000 |=>
        ram_select == ($past(dma_addr[14]) ? 2'h2 : 2'h1))
        else $error("wrong ram block");
    a_top_page: assert property (
        @(posedge clk_sys) disable iff (rst)
        dma_req && !io_req && dma_addr[23:16] == `PMD_LAST_PAGE |=>
        external_bank_selects_n == 4'hf &&
        boot_rom_select == ($past(dma_addr[15:0]) >= `PMD_BOOT_BASE))
        else $error("top page decoded off chip");
    a_bank_top: assert property (
        @(posedge clk_sys) disable iff (rst)
        dma_req && !io_req && dma_addr[23:16] >= bank_first_q[3] &&
        dma_addr[23:16] > `PMD_ROM_PAGE &&
        dma_addr[23:16] != `PMD_LAST_PAGE |=> external_bank_selects_n == 4'h7)
        else $error("bank 3 not selected");
    a_io_address: assert property (
        @(posedge clk_sys) disable iff (rst)
        io_req |=>
        io_address_bus == {$past(io_page_register_q), $past(io_ofs)})
        else $error("io address wrong");
    a_rom_map: assert property (
        @(posedge clk_sys) disable iff (rst)
        dma_req && !io_req && dma_addr[23:14] == 10'h004 |=> rom_select)
        else $error("program rom not selected");
endmodule
`default_nettype wire

// ---- pmd_core_model.sv ----
`default_nettype none
// ****
// Core side: sequencer and data address generators
// ****
module pmd_core_model (
    input wire logic clk_sys, // Core clock
    output logic seq_step, // Advance pc
    output var pmd_pkg::pmd_seq_type seq_sel, // Pc source
    output logic [15:0] seq_rel_ofs, // Relative offset
    output logic [23:0] seq_direct, // Direct target
    output logic [15:0] seq_ind_index, // Indirect low bits
    output logic jump_page_we, // Jump page load
    output logic [7:0] jump_page_wdata, // Jump page value
    output logic [1:0] dag_page_we, // Data page load
    output logic [7:0] dag_page_wdata, // Data page value
    output logic dag_req, // Data access
    output logic dag_sel, // Generator pick
    output logic [15:0] dag_index // Generator index
);
    timeunit 1ns;
    timeprecision 1ps;
    import pmd_pkg::*;
    // Idle values from time zero
    initial begin
        {seq_step, jump_page_we, dag_page_we, dag_req, dag_sel} = '0;
        seq_sel = PMD_SEQ_LINEAR;
        {seq_rel_ofs, seq_direct, seq_ind_index} = '0;
        {jump_page_wdata, dag_page_wdata, dag_index} = '0;
    end
    // Step just past the rising edge
    task automatic tick;
        @(posedge clk_sys);
        #2;
    endtask
    // One pc change; every indirect loads jump page first
    task automatic branch(input pmd_seq_type sel, input logic [23:0] tgt,
            input logic [15:0] ofs);
        tick();
        if (sel == PMD_SEQ_INDIRECT) begin
            jump_page_we = 1'b1;
            jump_page_wdata = tgt[23:16];
            tick();
            jump_page_we = 1'b0;
        end
        seq_step = 1'b1;
        seq_sel = sel;
        seq_direct = tgt;
        seq_ind_index = tgt[15:0];
        seq_rel_ofs = ofs;
        tick();
        seq_step = 1'b0;
    endtask
    // Data read; page register loaded before the access
    task automatic dag_read(input logic sel, input logic [7:0] page,
            input logic [15:0] idx);
        tick();
        dag_page_we = 2'h1 << sel;
        dag_page_wdata = page;
        tick();
        dag_page_we = 2'h0;
        dag_req = 1'b1;
        dag_sel = sel;
        dag_index = idx;
        tick();
        dag_req = 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pmd_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic peripheral_boot = 1'b1;
    logic rom_protect = 1'b0;
    logic dma_req = 1'b0, emu_req = 1'b0, io_page_we = 1'b0, io_req = 1'b0;
    logic bank_we = 1'b0, bank_wmode_in = 1'b0;
    logic [23:0] dma_addr = '0, emu_addr = '0;
    logic [7:0] io_page_wdata = '0, bank_wfirst = '0;
    logic [9:0] io_ofs = '0;
    logic [1:0] bank_wsel = '0;
    logic [3:0] bank_wait_in = '0;
    logic seq_step, jump_page_we, dag_req, dag_sel;
    pmd_seq_type seq_sel;
    logic [15:0] seq_rel_ofs, seq_ind_index, dag_index;
    logic [23:0] seq_direct, program_address_bus, data_address_bus;
    logic [7:0] jump_page_wdata, dag_page_wdata;
    logic [1:0] dag_page_we, ram_select;
    logic [17:0] io_address_bus;
    logic boot_rom_select, rom_select, io_reg_select, io_space_select_n;
    logic [3:0] external_bank_selects_n, ext_wait;
    logic ext_wait_mode, emu_refused;
    int n_fail = 0;
    int comparisons = 0;
    // ****
    // Map probes: address and {ram, boot, bank selects}
    // ****
    logic [23:0] map_a [11] = '{24'h000010, 24'h003fff, 24'h004000,
        24'h018000, 24'h3fffff, 24'h400000, 24'h7fffff, 24'h800000,
        24'hc00000, 24'hfeffff, 24'hfffc00};
    logic [6:0] map_e [11] = '{7'h2f, 7'h2f, 7'h4f, 7'h0e, 7'h0e, 7'h0d,
        7'h0d, 7'h0b, 7'h07, 7'h07, 7'h1f};
    pmd_decoder dut (.clk_sys, .rst, .peripheral_boot, .rom_protect,
        .seq_step, .seq_sel, .seq_rel_ofs, .seq_direct, .seq_ind_index,
        .jump_page_we, .jump_page_wdata, .dag_page_we, .dag_page_wdata,
        .dag_req, .dag_sel, .dag_index, .dma_req, .dma_addr, .emu_req,
        .emu_addr, .io_page_we, .io_page_wdata, .io_req, .io_ofs, .bank_we,
        .bank_wsel, .bank_wfirst, .bank_wait_in, .bank_wmode_in,
        .program_address_bus, .data_address_bus, .io_address_bus,
        .ram_select, .boot_rom_select, .rom_select, .io_reg_select,
        .external_bank_selects_n, .io_space_select_n, .ext_wait,
        .ext_wait_mode, .emu_refused);
    pmd_core_model core (.clk_sys, .seq_step, .seq_sel, .seq_rel_ofs,
        .seq_direct, .seq_ind_index, .jump_page_we, .jump_page_wdata,
        .dag_page_we, .dag_page_wdata, .dag_req, .dag_sel, .dag_index);
    // 50 MHz core clock
    always #10 clk_sys = ~clk_sys;
    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic tick;
        @(posedge clk_sys);
        #2;
    endtask
    // One-cycle DMA and emulator requests
    task automatic dma_at(input logic [23:0] a);
        tick();
        dma_req = 1'b1;
        dma_addr = a;
        tick();
        dma_req = 1'b0;
    endtask
    task automatic emu_at(input logic [23:0] a);
        tick();
        emu_req = 1'b1;
        emu_addr = a;
        tick();
        emu_req = 1'b0;
    endtask
    task automatic t_boot;
        repeat (3) tick();
        chk("pc", 24'hfffc00, program_address_bus);
        chk("boot", 1'b1, boot_rom_select);
        chk("others", 6'h0f, {ram_select, external_bank_selects_n});
    endtask
    task automatic t_map;
        for (int i = 0; i < 11; i++) begin
            dma_at(map_a[i]);
            chk("dbus", map_a[i], data_address_bus);
            chk("sel", map_e[i], {ram_select, boot_rom_select,
                external_bank_selects_n});
        end
        dma_at(24'hff0000);
        chk("top", 7'h0f, {ram_select, boot_rom_select,
            external_bank_selects_n});
        dma_at(24'h013fff);
        chk("rommap", 5'h1f, {rom_select, external_bank_selects_n});
    endtask
    task automatic t_dag;
        core.dag_read(1'b1, 8'h40, 16'h1234);
        chk("dag1", 24'h401234, data_address_bus);
        chk("bank", 4'hd, external_bank_selects_n);
        core.dag_read(1'b0, 8'h00, 16'h4001);
        chk("ram", 2'h2, ram_select);
    endtask
    task automatic t_io(input logic [7:0] p);
        logic in;
        in = (p <= 8'h1f);
        tick();
        io_page_we = 1'b1;
        io_page_wdata = p;
        tick();
        io_page_we = 1'b0;
        io_req = 1'b1;
        io_ofs = 10'h2a5;
        tick();
        io_req = 1'b0;
        chk("ioaddr", {p, 10'h2a5}, io_address_bus);
        chk("iosel", {in, in}, {io_reg_select, io_space_select_n});
        chk("memsel", 7'h0f, {ram_select, boot_rom_select,
            external_bank_selects_n});
    endtask
    task automatic t_seq(input pmd_seq_type s, input logic [23:0] t,
            input logic [15:0] o, input logic [23:0] e);
        core.branch(s, t, o);
        tick();
        chk("pc", e, program_address_bus);
    endtask
    task automatic t_emu;
        rom_protect = 1'b1;
        emu_at(24'h010100);
        chk("romref", 2'h2, {emu_refused, rom_select});
        emu_at(24'hfffc10);
        chk("bootref", 2'h2, {emu_refused, boot_rom_select});
        rom_protect = 1'b0;
        emu_at(24'h010100);
        chk("rom", 2'h1, {emu_refused, rom_select});
    endtask
    task automatic t_banks;
        tick();
        bank_we = 1'b1;
        bank_wsel = 2'h1;
        bank_wfirst = 8'h50;
        bank_wait_in = 4'h3;
        bank_wmode_in = 1'b1;
        tick();
        bank_we = 1'b0;
        dma_at(24'h480000);
        chk("b0", 9'h1c0, {external_bank_selects_n, ext_wait,
            ext_wait_mode});
        dma_at(24'h500000);
        chk("b1", 9'h1a7, {external_bank_selects_n, ext_wait,
            ext_wait_mode});
    endtask
    // Second reset: plain boot from zero, default banks back
    task automatic t_reset;
        tick();
        rst = 1'b1;
        peripheral_boot = 1'b0;
        repeat (2) tick();
        rst = 1'b0;
        repeat (3) tick();
        chk("pc0", 24'h000000, program_address_bus);
        chk("sel0", 4'h4, {ram_select, boot_rom_select, rom_select});
        dma_at(24'h480000);
        chk("rstbank", 9'h1a0, {external_bank_selects_n, ext_wait,
            ext_wait_mode});
    endtask
    // ****
    // Main sequence and watchdog
    // ****
    initial begin
        repeat (6) @(posedge clk_sys);
        #2;
        rst = 1'b0;
        t_boot();
        t_map();
        t_dag();
        t_io(8'h00);
        t_io(8'h1f);
        t_io(8'h20);
        t_io(8'hff);
        t_seq(PMD_SEQ_DIRECT, 24'h123456, 16'h0, 24'h123456);
        t_seq(PMD_SEQ_LINEAR, 24'h0, 16'h0, 24'h123457);
        t_seq(PMD_SEQ_RELATIVE, 24'h0, 16'hfff0, 24'h123447);
        t_seq(PMD_SEQ_INDIRECT, 24'h7abeef, 16'h0, 24'h7abeef);
        t_emu();
        t_banks();
        t_reset();
        summarize();
    end
    initial begin
        #100000;
        n_fail++;
        summarize();
    end
endmodule
`default_nettype wire
